// [src/gdp_dev.sv]
// Device end: gear-down capture mode and maximum power-saving state.
// Assumes link pins come from another domain; all are synchronised here.
//
// Functional notes
// - Default single_cycle_capture after reset
// - Two-cycle mode only at fast grades
// - Controller enables gear only init/SRX; gdp_ctl allows it in any idle cycle out of SR, as cnt is always 0 in idle
// - Single-cycle needs no write or pulse
// - Gear write held N, one-cycle select
// - Sync pulse an even count later
// - two_cycle_capture after command_gear_delay
// - Self refresh reverts to single cycle
// - Leave two-cycle only via self refresh
// - Gear resume via gear_select_bit after exit
// - Only refresh before gear write
// - Commands wait gear or DLL delay
// - Stay single: wait exit delay only
// - Even latencies in two-cycle mode
// - Power-save ignores all but exit, reset
// - Power-save entered by mode write
// - Disable parity, latency, gear before entry
// - After entry delay, only cke/cs/reset
// - Clock held until power_save_clock_hold
// - Cke rise, cs high: stay saving
// - Cke rise, cs low: clear, exit
// - Clock restarted before exit
// - Nop then deselect during exit delay
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module gdp_dev
   import gdp_pkg::*;
#(
   parameter bit FAST_GRADE = 1'b1
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   gdp_if.dev        lnk,
   output logic      two_cycle_capture_o,
   output logic      self_refresh_o,
   output logic      power_save_o,
   output logic      cmd_ready_o,
   output logic      dll_ready_o,
   output logic      ignored_o
);
   typedef enum logic [4:0] {
      GDP_D_IDLE   = 5'h01,
      GDP_D_SYNC   = 5'h02,
      GDP_D_GEAR   = 5'h04,
      GDP_D_MPE    = 5'h08,
      GDP_D_MPX    = 5'h10
   } gdp_dst_t;

   // ***************************************************
   // Pin synchronisers
   // ***************************************************
   logic [12:0] s1;
   logic [12:0] s2;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1 <= 13'h1001;
         s2 <= 13'h1001;
      end else if (ce_i) begin
         s1 <= {lnk.rst_n, lnk.addr, lnk.cmd[2:1], lnk.cmd[0] ^ 1'b0, 1'b0} |
               {12'h000, lnk.cs_n} ;
         s2 <= s1;
      end
   end
   logic       cs_n;
   logic       rst_n;
   logic [2:0] cmd;
   logic [7:0] addr;
   logic       cke_s1;
   logic       cke_s2;
   logic       cke_d;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cke_s1 <= 1'b0;
         cke_s2 <= 1'b0;
         cke_d  <= 1'b0;
      end else if (ce_i) begin
         cke_s1 <= lnk.cke;
         cke_s2 <= cke_s1;
         cke_d  <= cke_s2;
      end
   end
   assign cs_n  = s2[0];
   assign cmd   = s2[3:1];
   assign addr  = s2[11:4];
   assign rst_n = s2[12];

   wire  cke_rise = cke_s2 & ~cke_d;
   wire  sel      = ~cs_n & cke_s2;
   wire  mr_wr    = sel & (cmd == GDP_CMD_MRW);
   wire  gear_wr  = mr_wr & (addr[7:4] == GDP_MR3) & addr[GDP_GEAR_BIT];
   wire  mps_wr   = mr_wr & (addr[7:4] == GDP_MR4) & addr[GDP_MPS_BIT];

   // ***************************************************
   // Mode state machine
   // ***************************************************
   gdp_dst_t state;
   logic     clr;
   logic     ld_gear;
   logic     ld_mped;
   logic     ld_xmp;
   logic     ld_dll;
   logic     gear_done;
   logic     mped_done;
   logic     xmp_done;
   logic     dll_done;
   logic     sync_par;
   assign clr = rst_i | ~rst_n;

   always_ff @(posedge clk_i) begin
      if (clr) begin
         state               <= GDP_D_IDLE;
         two_cycle_capture_o <= 1'b0;
         self_refresh_o      <= 1'b0;
         power_save_o        <= 1'b0;
         sync_par            <= 1'b0;
         ignored_o           <= 1'b0;
      end else if (ce_i) begin
         ignored_o <= 1'b0;
         sync_par  <= ~sync_par;
         case (state)
            GDP_D_IDLE: begin
               if (sel && cmd == GDP_CMD_SRE) begin
                  self_refresh_o      <= 1'b1;
                  two_cycle_capture_o <= 1'b0;
               end else if (sel && cmd == GDP_CMD_SRX) begin
                  self_refresh_o <= 1'b0;
               end else if (gear_wr && FAST_GRADE && !two_cycle_capture_o) begin
                  state    <= GDP_D_SYNC;
                  sync_par <= 1'b1;
               end else if (mps_wr) begin
                  state <= GDP_D_MPE;
               end
            end
            GDP_D_SYNC: begin
               // Pulse on even spacing only aligns the half-rate phase
               if (sel && cmd == GDP_CMD_NOP && !sync_par) begin
                  state <= GDP_D_GEAR;
               end
            end
            GDP_D_GEAR: begin
               if (gear_done) begin
                  two_cycle_capture_o <= 1'b1;
                  state               <= GDP_D_IDLE;
               end
            end
            GDP_D_MPE: begin
               if (mped_done) begin
                  power_save_o <= 1'b1;
               end
               if (power_save_o && cke_rise) begin
                  if (!cs_n) begin
                     power_save_o <= 1'b0;
                     state        <= GDP_D_MPX;
                  end else begin
                     ignored_o <= 1'b1;
                  end
               end else if (power_save_o && sel) begin
                  ignored_o <= 1'b1;
               end
            end
            GDP_D_MPX: begin
               if (xmp_done) begin
                  state <= GDP_D_IDLE;
               end
            end
            default: begin
               state <= GDP_D_IDLE;
            end
         endcase
      end
   end

   assign ld_gear = (state == GDP_D_SYNC) & sel & (cmd == GDP_CMD_NOP) & ~sync_par;
   assign ld_mped = (state == GDP_D_IDLE) & mps_wr;
   assign ld_xmp  = (state == GDP_D_MPE) & power_save_o & cke_rise & ~cs_n;
   assign ld_dll  = ld_gear | ld_xmp;

   gdp_cnt #(.W(8)) u_gear (
      .clk_i  (clk_i),
      .ce_i   (ce_i),
      .clr_i  (clr),
      .load_i (ld_gear),
      .val_i  (8'(GDP_GEAR_CYC)),
      .done_o (gear_done)
   );
   gdp_cnt #(.W(8)) u_mped (
      .clk_i  (clk_i),
      .ce_i   (ce_i),
      .clr_i  (clr),
      .load_i (ld_mped),
      .val_i  (8'(GDP_MPED_CYC)),
      .done_o (mped_done)
   );
   gdp_cnt #(.W(8)) u_xmp (
      .clk_i  (clk_i),
      .ce_i   (ce_i),
      .clr_i  (clr),
      .load_i (ld_xmp),
      .val_i  (8'(GDP_XMP_CYC)),
      .done_o (xmp_done)
   );
   gdp_cnt #(.W(8)) u_dll (
      .clk_i  (clk_i),
      .ce_i   (ce_i),
      .clr_i  (clr),
      .load_i (ld_dll),
      .val_i  (8'(GDP_XMP_DLL_CYC)),
      .done_o (dll_done)
   );

   // ***************************************************
   // Readiness flags
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (clr) begin
         cmd_ready_o <= 1'b0;
         dll_ready_o <= 1'b0;
      end else if (ce_i) begin
         cmd_ready_o <= (state == GDP_D_IDLE) & ~self_refresh_o;
         dll_ready_o <= (state == GDP_D_IDLE) & ~self_refresh_o & dll_done & ~ld_dll;
      end
   end
endmodule

// [src/gdp_pkg.sv]
// Constants shared by both ends of the gear-down / power-save link.
// Assumes a 40 MHz system clock on both ends.
package gdp_pkg;
   // ***************************************************
   // Command encoding on the simplified command bus
   // ***************************************************
   localparam logic [2:0] GDP_CMD_NOP  = 3'h0;
   localparam logic [2:0] GDP_CMD_MRW  = 3'h1;
   localparam logic [2:0] GDP_CMD_SRE  = 3'h2;
   localparam logic [2:0] GDP_CMD_SRX  = 3'h3;
   localparam logic [2:0] GDP_CMD_REF  = 3'h4;
   localparam logic [2:0] GDP_CMD_ACT  = 3'h5;
   localparam logic [2:0] GDP_CMD_DLL  = 3'h6;
   // Mode register fields: address bits [7:4] select register, [3:0] data
   localparam logic [3:0] GDP_MR3      = 4'h3;
   localparam logic [3:0] GDP_MR4      = 4'h4;
   localparam int         GDP_GEAR_BIT = 3;
   localparam int         GDP_MPS_BIT  = 1;
   // ***************************************************
   // Timing (ns) and derived cycle counts at 40 MHz
   // ***************************************************
   localparam int GDP_CLK_NS        = 25;
   localparam int GDP_CMD_GEAR_NS   = 200;
   localparam int GDP_MPED_NS       = 250;
   localparam int GDP_CKMPE_NS      = 300;
   localparam int GDP_XMP_NS        = 500;
   localparam int GDP_XMP_DLL_NS    = 1000;
   localparam int GDP_GEAR_CYC      = (GDP_CMD_GEAR_NS + GDP_CLK_NS - 1) / GDP_CLK_NS;
   localparam int GDP_MPED_CYC      = (GDP_MPED_NS + GDP_CLK_NS - 1) / GDP_CLK_NS;
   localparam int GDP_CKMPE_CYC     = (GDP_CKMPE_NS + GDP_CLK_NS - 1) / GDP_CLK_NS;
   localparam int GDP_XMP_CYC       = (GDP_XMP_NS + GDP_CLK_NS - 1) / GDP_CLK_NS;
   localparam int GDP_XMP_DLL_CYC   = (GDP_XMP_DLL_NS + GDP_CLK_NS - 1) / GDP_CLK_NS;
   localparam int GDP_SYNC_GAP      = 2;
   // ***************************************************
   // Wishbone register map of the controller
   // ***************************************************
   localparam logic [3:0] GDP_REG_CTRL = 4'h0;
   localparam logic [3:0] GDP_REG_STAT = 4'h4;
   localparam int GDP_CTRL_GEAR    = 0;
   localparam int GDP_CTRL_SRE     = 1;
   localparam int GDP_CTRL_SRX     = 2;
   localparam int GDP_CTRL_MPS_IN  = 3;
   localparam int GDP_CTRL_MPS_OUT = 4;
   localparam int GDP_CTRL_FAST    = 5;
endpackage

// [src/gdp_if.sv]
// Command link between memory controller and device.
// Assumes one shared clock; device clock is the same clk_i.
`timescale 1ns/1ps
interface gdp_if;
   logic       cs_n;
   logic       cke;
   logic       rst_n;
   logic [2:0] cmd;
   logic [7:0] addr;
   modport ctrl (output cs_n, output cke, output rst_n, output cmd, output addr);
   modport dev  (input cs_n, input cke, input rst_n, input cmd, input addr);
endinterface

// [src/gdp_cnt.sv]
// Loadable down counter with done flag.
// Assumes same clock and enable as its parent.
`timescale 1ns/1ps
module gdp_cnt #(
   parameter int W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         ce_i,
   input  wire logic         clr_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] val_i,
   output logic              done_o
);
   logic [W-1:0] cnt;
   always_ff @(posedge clk_i) begin
      if (clr_i) begin
         cnt <= '0;
      end else if (ce_i) begin
         if (load_i) begin
            cnt <= val_i;
         end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
         end
      end
   end
   assign done_o = (cnt == '0);
endmodule

// [src/gdp_ctl.sv]
// Controller end: runs gear-down and power-save sequences on orders
// taken over classic Wishbone. Assumes the device shares clk_i.
`timescale 1ns/1ps
module gdp_ctl
   import gdp_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   gdp_if.ctrl              lnk
);
   typedef enum logic [7:0] {
      GDP_C_INIT  = 8'h01,
      GDP_C_IDLE  = 8'h02,
      GDP_C_GWR   = 8'h04,
      GDP_C_SYNC  = 8'h08,
      GDP_C_WAIT  = 8'h10,
      GDP_C_MPE   = 8'h20,
      GDP_C_MPX   = 8'h40,
      GDP_C_XNOP  = 8'h80
   } gdp_cst_t;

   gdp_cst_t   state;
   logic [5:0] ctrl;
   logic       two_cycle;
   logic       in_sr;
   logic       in_mps;
   logic [7:0] cnt;
   logic       first_srx;

   // ***************************************************
   // Wishbone slave: one wait state, unmapped reads zero
   // ***************************************************
   wire req = cyc_i & stb_i & ~ack_o;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else if (ce_i) begin
         ack_o <= req;
         dat_o <= 32'h0;
         if (req && !we_i && adr_i == GDP_REG_STAT) begin
            dat_o <= {24'h0, state};
         end else if (req && !we_i && adr_i == GDP_REG_CTRL) begin
            dat_o <= {24'h0, 1'b0, in_mps, ctrl};
         end
      end
   end

   // ***************************************************
   // Sequencer; order bits self-clear once taken
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state     <= GDP_C_INIT;
         ctrl      <= 6'h20;
         two_cycle <= 1'b0;
         in_sr     <= 1'b0;
         in_mps    <= 1'b0;
         cnt       <= 8'h0;
         first_srx <= 1'b0;
         lnk.cs_n  <= 1'b1;
         lnk.cke   <= 1'b0;
         lnk.rst_n <= 1'b0;
         lnk.cmd   <= GDP_CMD_NOP;
         lnk.addr  <= 8'h0;
      end else if (ce_i) begin
         lnk.rst_n <= 1'b1;
         lnk.cs_n  <= 1'b1;
         if (cnt != 8'h0) begin
            cnt <= cnt - 1'b1;
         end
         case (state)
            GDP_C_INIT: begin
               lnk.cke <= 1'b1;
               state   <= GDP_C_IDLE;
            end
            GDP_C_IDLE: begin
               if (ctrl[GDP_CTRL_SRE] && !in_sr) begin
                  lnk.cs_n  <= 1'b0;
                  lnk.cmd   <= GDP_CMD_SRE;
                  in_sr     <= 1'b1;
                  two_cycle <= 1'b0;
                  ctrl[GDP_CTRL_SRE] <= 1'b0;
               end else if (ctrl[GDP_CTRL_SRX] && in_sr) begin
                  lnk.cs_n  <= 1'b0;
                  lnk.cmd   <= GDP_CMD_SRX;
                  in_sr     <= 1'b0;
                  first_srx <= 1'b1;
                  ctrl[GDP_CTRL_SRX] <= 1'b0;
               end else if (ctrl[GDP_CTRL_GEAR] && ctrl[GDP_CTRL_FAST] && !two_cycle
                            && !in_sr && (first_srx || cnt == 8'h0)) begin
                  lnk.cs_n <= 1'b0;
                  lnk.cmd  <= GDP_CMD_MRW;
                  lnk.addr <= {GDP_MR3, 4'h8};
                  cnt      <= 8'(GDP_SYNC_GAP);
                  state    <= GDP_C_GWR;
               end else if (ctrl[GDP_CTRL_MPS_IN] && !in_sr && !two_cycle) begin
                  lnk.cs_n <= 1'b0;
                  lnk.cmd  <= GDP_CMD_MRW;
                  lnk.addr <= {GDP_MR4, 4'h2};
                  cnt      <= 8'(GDP_CKMPE_CYC + GDP_MPED_CYC);
                  ctrl[GDP_CTRL_MPS_IN] <= 1'b0;
                  state    <= GDP_C_MPE;
               end
            end
            GDP_C_GWR: begin
               // Command stays on the bus; only select is one cycle
               if (cnt == 8'h1) begin
                  lnk.cmd  <= GDP_CMD_NOP;
                  lnk.cs_n <= 1'b0;
                  cnt      <= 8'(GDP_GEAR_CYC + 1);
                  state    <= GDP_C_WAIT;
               end
            end
            GDP_C_WAIT: begin
               if (cnt == 8'h0) begin
                  two_cycle <= 1'b1;
                  first_srx <= 1'b0;
                  ctrl[GDP_CTRL_GEAR] <= 1'b0;
                  state     <= GDP_C_IDLE;
               end
            end
            GDP_C_MPE: begin
               if (cnt == 8'h0) begin
                  in_mps <= 1'b1;
                  if (ctrl[GDP_CTRL_MPS_OUT]) begin
                     lnk.cke  <= 1'b0;
                     state    <= GDP_C_MPX;
                  end
               end
            end
            GDP_C_MPX: begin
               // Clock never stops here, so restart is already met
               lnk.cs_n <= 1'b0;
               lnk.cke  <= 1'b1;
               lnk.cmd  <= GDP_CMD_NOP;
               cnt      <= 8'(GDP_XMP_CYC + 4);
               ctrl[GDP_CTRL_MPS_OUT] <= 1'b0;
               state    <= GDP_C_XNOP;
            end
            GDP_C_XNOP: begin
               if (cnt > 8'(GDP_XMP_CYC)) begin
                  lnk.cs_n <= 1'b0;
               end
               if (cnt == 8'h0) begin
                  in_mps <= 1'b0;
                  state  <= GDP_C_IDLE;
               end
            end
            default: begin
               state <= GDP_C_IDLE;
            end
         endcase
         // Late, so a fresh order beats a self-clear on the same edge
         if (cyc_i && stb_i && ack_o && we_i && sel_i[0] && adr_i == GDP_REG_CTRL) begin
            ctrl <= dat_i[5:0];
         end
      end
   end
endmodule

// [sim/gdp_assertions.sv]
// Checker for the command link between controller and device end.
// Assumes it sits beside the link in the bench top, fed by plain signals.
`timescale 1ns/1ps
module gdp_assertions
   import gdp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       cs_n,
   input  wire logic       cke,
   input  wire logic [2:0] cmd,
   input  wire logic [7:0] addr,
   input  wire logic       two_cycle_capture_o,
   input  wire logic       self_refresh_o,
   input  wire logic       power_save_o
);
   logic sel_mrw;
   logic gear_wr;
   logic mps_wr;
   assign sel_mrw = !cs_n && cmd == GDP_CMD_MRW;
   assign gear_wr = sel_mrw && addr[7:4] == GDP_MR3 && addr[GDP_GEAR_BIT];
   assign mps_wr  = sel_mrw && addr[7:4] == GDP_MR4 && addr[GDP_MPS_BIT];
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ***************************************************
   // Link and device state relations
   // ***************************************************
   reset_single_a: assert property ($fell(rst_i) |-> !two_cycle_capture_o && !power_save_o)
      else $error("capture mode not single after reset");
   select_one_a: assert property (sel_mrw |=> cs_n)
      else $error("mode write select longer than one cycle");
   mrw_held_a: assert property (sel_mrw |=> cmd == GDP_CMD_MRW)
      else $error("mode write command not held");
   sync_even_a: assert property (gear_wr |=> cs_n ##1 (!cs_n && cmd == GDP_CMD_NOP) ##1 cs_n)
      else $error("sync pulse not two cycles after gear write");
   // Lower bound matters: capture must not switch before the gear delay
   gear_delay_a: assert property (gear_wr ##2 !cs_n |->
      !two_cycle_capture_o [*8] ##[1:10] two_cycle_capture_o)
      else $error("two cycle capture timing wrong");
   sre_revert_a: assert property (!cs_n && cmd == GDP_CMD_SRE |->
      ##[1:8] (self_refresh_o && !two_cycle_capture_o))
      else $error("self refresh did not revert capture");
   ps_entry_a: assert property (mps_wr |-> !power_save_o [*8] ##[1:12] power_save_o)
      else $error("power save entry timing wrong");
   ps_exit_a: assert property (power_save_o && $rose(cke) && !cs_n |-> ##[1:8] !power_save_o)
      else $error("power save not left on select with clock enable");
   ps_stay_a: assert property (power_save_o && $rose(cke) && cs_n |-> power_save_o [*8])
      else $error("power save left without select");
   cover property (gear_wr);
   cover property (mps_wr);
   cover property ($fell(power_save_o));
endmodule

// [sim/tb.sv]
// Bench top: controller and device joined by one link, plus a slow-grade
// device on a second link that the bench drives directly for misuse.
// Assumes the package, link and design modules are compiled first.
`timescale 1ns/1ps
module tb;
   import gdp_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [3:0]  adr_i = 4'h0;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   wire  [11:0] st;
   logic [31:0] exp_q[$];
   logic [31:0] lfsr     = 32'hc8baa4d8;
   logic        ign_seen = 1'b0;
   int          mismatches = 0;
   int          tests_run  = 0;
   int          cycles     = 0;

   always #12.5 clk_i = ~clk_i;

   gdp_if lnk ();
   gdp_if lnk2 ();

   gdp_ctl i_gdp_ctl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .lnk(lnk));
   gdp_dev i_gdp_dev (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .lnk(lnk),
      .two_cycle_capture_o(st[0]), .self_refresh_o(st[1]), .power_save_o(st[2]),
      .cmd_ready_o(st[3]), .dll_ready_o(st[4]), .ignored_o(st[5]));
   // Slow grade on purpose: gear-down must never take effect there
   if (1) begin : g_far
      gdp_dev #(.FAST_GRADE(1'b0)) i_gdp_dev (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
         .lnk(lnk2), .two_cycle_capture_o(st[6]), .self_refresh_o(st[7]),
         .power_save_o(st[8]), .cmd_ready_o(st[9]), .dll_ready_o(st[10]),
         .ignored_o(st[11]));
   end
   gdp_assertions i_gdp_assertions (.clk_i(clk_i), .rst_i(rst_i), .cs_n(lnk.cs_n),
      .cke(lnk.cke), .cmd(lnk.cmd), .addr(lnk.addr), .two_cycle_capture_o(st[0]),
      .self_refresh_o(st[1]), .power_save_o(st[2]));

   // ***************************************************
   // Helpers
   // ***************************************************
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      // A read that never got its answer counts against the run
      if (exp_q.size() != 0) mismatches++;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] e);
      if (!w) exp_q.push_back(e);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      // Ack ends this wait; without ack only the bench timeout ends it
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wt(input int k, input logic v);
      int n;
      n = 0;
      while (st[k] !== v && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      check({31'h0, st[k]}, {31'h0, v});
   endtask

   // Address lines take a fresh random value in every deselected NOP cycle so stale values never help
   task automatic d2(input logic cs, input logic ck, input logic [2:0] c,
                     input logic [7:0] a, input int n);
      for (int i = 0; i < n; i++) begin
         lfsr = nxt(lfsr);
         lnk2.cs_n <= cs;
         lnk2.cke  <= ck;
         lnk2.cmd  <= c;
         lnk2.addr <= (cs && c == GDP_CMD_NOP) ? lfsr[7:0] : a;
         @(posedge clk_i);
      end
   endtask

   // ***************************************************
   // Result watcher and hang guard
   // ***************************************************
   always @(posedge clk_i) begin
      cycles++;
      if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
         check(dat_o, exp_q.pop_front());
      end
      if (st[11] === 1'b1) ign_seen <= 1'b1;
      if (cycles > 20000) begin
         mismatches++;
         complete_run();
      end
   end

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      lnk2.cs_n  = 1'b1;
      lnk2.cke   = 1'b0;
      lnk2.rst_n = 1'b0;
      lnk2.cmd   = GDP_CMD_NOP;
      lnk2.addr  = 8'h00;
      repeat (6) @(posedge clk_i);
      rst_i      <= 1'b0;
      lnk2.rst_n <= 1'b1;
      @(posedge clk_i);
      wt(0, 1'b0);
      wb(1'b0, GDP_REG_CTRL, 32'h0, 32'h20);
      wb(1'b0, GDP_REG_STAT, 32'h0, 32'h2);
      lfsr = nxt(lfsr);
      wb(1'b1, 4'h8, lfsr, 32'h0);
      wb(1'b0, 4'h8, 32'h0, 32'h0);
      wb(1'b0, GDP_REG_CTRL, 32'h0, 32'h20);
      wt(3, 1'b1);
      wb(1'b1, GDP_REG_CTRL, 32'h21, 32'h0);
      wt(0, 1'b1);
      check({31'h0, st[4]}, 32'h0);
      wt(4, 1'b1);
      wt(3, 1'b1);
      wb(1'b1, GDP_REG_CTRL, 32'h22, 32'h0);
      wt(1, 1'b1);
      wt(0, 1'b0);
      wb(1'b1, GDP_REG_CTRL, 32'h24, 32'h0);
      wt(1, 1'b0);
      wt(3, 1'b1);
      wb(1'b1, GDP_REG_CTRL, 32'h21, 32'h0);
      wt(0, 1'b1);
      wt(3, 1'b1);
      wb(1'b1, GDP_REG_CTRL, 32'h22, 32'h0);
      wt(1, 1'b1);
      wb(1'b1, GDP_REG_CTRL, 32'h24, 32'h0);
      wt(1, 1'b0);
      wt(0, 1'b0);
      wt(3, 1'b1);
      wb(1'b1, GDP_REG_CTRL, 32'h28, 32'h0);
      wt(2, 1'b1);
      wb(1'b1, GDP_REG_CTRL, 32'h30, 32'h0);
      wt(2, 1'b0);
      wt(3, 1'b1);
      // Far device: gear write on a slow grade, then power-save misuse
      d2(1'b1, 1'b1, GDP_CMD_NOP, 8'h00, 6);
      d2(1'b0, 1'b1, GDP_CMD_MRW, 8'h38, 1);
      d2(1'b1, 1'b1, GDP_CMD_MRW, 8'h38, 1);
      d2(1'b0, 1'b1, GDP_CMD_NOP, 8'h00, 1);
      d2(1'b1, 1'b1, GDP_CMD_NOP, 8'h00, 4 * GDP_GEAR_CYC);
      check({31'h0, st[6]}, 32'h0);
      d2(1'b0, 1'b1, GDP_CMD_MRW, 8'h42, 1);
      d2(1'b1, 1'b1, GDP_CMD_MRW, 8'h42, 1);
      d2(1'b1, 1'b1, GDP_CMD_NOP, 8'h00, 1);
      wt(8, 1'b1);
      d2(1'b0, 1'b1, GDP_CMD_SRE, 8'h00, 1);
      d2(1'b1, 1'b1, GDP_CMD_NOP, 8'h00, 8);
      check({31'h0, st[7]}, 32'h0);
      check({31'h0, ign_seen}, 32'h1);
      d2(1'b1, 1'b0, GDP_CMD_NOP, 8'h00, 4);
      d2(1'b1, 1'b1, GDP_CMD_NOP, 8'h00, 8);
      check({31'h0, st[8]}, 32'h1);
      d2(1'b1, 1'b0, GDP_CMD_NOP, 8'h00, 4);
      d2(1'b0, 1'b0, GDP_CMD_NOP, 8'h00, 1);
      d2(1'b0, 1'b1, GDP_CMD_NOP, 8'h00, 3);
      d2(1'b1, 1'b1, GDP_CMD_NOP, 8'h00, 1);
      wt(8, 1'b0);
      wt(10, 1'b1);
      wt(9, 1'b1);
      check({31'h0, st[5]}, 32'h0);
      complete_run();
   end
endmodule
